// File: hdl/depc_pkg.sv
// Shared constants and types for the dual encoder position counter
package depc_pkg;

  // ==========================================================================
  // Modes
  typedef enum logic [1:0] {
    DEPC_IN_DIFF_QUAD   = 2'h0,
    DEPC_IN_HTL_QUAD    = 2'h1,
    DEPC_IN_DIFF_STATIC = 2'h2,
    DEPC_IN_HTL_STATIC  = 2'h3
  } depc_intype_t;

  typedef enum logic [1:0] {
    DEPC_EDGE_X1 = 2'h0,
    DEPC_EDGE_X2 = 2'h1,
    DEPC_EDGE_X4 = 2'h2
  } depc_edge_t;

  // ==========================================================================
  // Values after reset
  localparam logic [1:0]        DEPC_INTYPE_RST = 2'h1;
  localparam logic [1:0]        DEPC_EDGE_RST   = 2'h0;
  localparam logic              DEPC_DIR_RST    = 1'h0;
  localparam logic signed [31:0] DEPC_PRESET_RST = 32'sh0;
  localparam logic signed [31:0] DEPC_COUNT_RST  = 32'sh0;
  localparam logic [9:0]        DEPC_MULT_RST   = 10'h1;
  localparam logic [19:0]       DEPC_SCALE_RST  = 20'h186a0;
  localparam logic [19:0]       DEPC_LOOP_RST   = 20'h0;

  // ==========================================================================
  // Ranges; scale is held in units of 0.00001
  localparam int DEPC_PRESET_MIN = -199999;
  localparam int DEPC_PRESET_MAX = 999999;
  localparam int DEPC_LOOP_MAX   = 999999;
  localparam int DEPC_SCALE_ONE  = 100000;
  localparam int DEPC_SCALE_MIN  = 1;
  localparam int DEPC_SCALE_MAX  = 999999;
  localparam int DEPC_MULT_MIN   = 1;
  localparam int DEPC_MULT_MAX1  = 99;
  localparam int DEPC_MULT_MAX2  = 999;

  // ==========================================================================
  // Load function codes
  localparam logic [3:0] DEPC_CMD_LOAD1    = 4'h4;
  localparam logic [3:0] DEPC_CMD_LOAD2    = 4'h5;
  localparam logic [3:0] DEPC_CMD_LOADBOTH = 4'h6;

endpackage : depc_pkg

// File: hdl/depc_evt_if.sv
// Count event carrier from a channel decoder to the counting core
`timescale 1ns/1ns
`default_nettype none
interface depc_evt_if;
  logic pulse;
  logic up;
  modport src (output pulse, output up);
  modport snk (input pulse, input up);
endinterface : depc_evt_if
`default_nettype wire

// File: hdl/depc_quad_decode.sv
// One encoder channel: pin synchroniser and edge decoder
`timescale 1ns/1ns
`default_nettype none
module depc_quad_decode (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       aPin,
  input  wire logic       bPin,
  input  wire logic [1:0] inputType,
  input  wire logic [1:0] edgeMode,
  depc_evt_if.src         evt
);

  // ==========================================================================
  // Synchronisers
  logic [2:0] aSync_ff;
  logic [2:0] bSync_ff;
  logic       aLvl_ff;
  logic       bLvl_ff;
  logic       pulse_ff;
  logic       up_ff;
  logic       nxt_aLvl;
  logic       nxt_bLvl;
  logic       nxt_pulse;
  logic       nxt_up;
  logic       aRise;
  logic       aChg;
  logic       bChg;
  logic       quad;

  // ==========================================================================
  // Edge decode
  always_comb begin
    // Level accepted only once stages two and three agree
    nxt_aLvl = (aSync_ff[1] == aSync_ff[2]) ? aSync_ff[1] : aLvl_ff;
    nxt_bLvl = (bSync_ff[1] == bSync_ff[2]) ? bSync_ff[1] : bLvl_ff;
    aRise    = nxt_aLvl & ~aLvl_ff;
    aChg     = nxt_aLvl ^ aLvl_ff;
    bChg     = nxt_bLvl ^ bLvl_ff;
    quad     = (inputType == depc_pkg::DEPC_IN_DIFF_QUAD) ||
               (inputType == depc_pkg::DEPC_IN_HTL_QUAD); // RL2
    unique case (edgeMode) // RL3
      depc_pkg::DEPC_EDGE_X1: nxt_pulse = aRise;
      depc_pkg::DEPC_EDGE_X2: nxt_pulse = aChg;
      depc_pkg::DEPC_EDGE_X4: nxt_pulse = quad ? (aChg | bChg) : aChg;
      default:                nxt_pulse = aRise;
    endcase
    // Static mode: B low means forward
    if (!quad) begin
      nxt_up = ~nxt_bLvl; // RL2
    end else if (aChg) begin
      nxt_up = (nxt_aLvl != bLvl_ff);
    end else begin
      nxt_up = (nxt_bLvl == aLvl_ff);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      // Keep tracking in reset, so a pin left high gives no false edge
      aSync_ff <= {aSync_ff[1:0], aPin};
      bSync_ff <= {bSync_ff[1:0], bPin};
      aLvl_ff  <= nxt_aLvl;
      bLvl_ff  <= nxt_bLvl;
      pulse_ff <= 1'h0;
      up_ff    <= 1'h1;
    end else begin
      aSync_ff <= {aSync_ff[1:0], aPin};
      bSync_ff <= {bSync_ff[1:0], bPin};
      aLvl_ff  <= nxt_aLvl;
      bLvl_ff  <= nxt_bLvl;
      pulse_ff <= nxt_pulse;
      up_ff    <= nxt_up;
    end
  end

  assign evt.pulse = pulse_ff;
  assign evt.up    = up_ff;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_x1_rise_only: assert property ( // RL3
    (edgeMode == depc_pkg::DEPC_EDGE_X1) && !aRise |=> !evt.pulse)
    else $error("x1 counted without a rising A");
  a_x4_b_edge: assert property ( // RL3
    quad && (edgeMode == depc_pkg::DEPC_EDGE_X4) && bChg && !aChg
    |=> evt.pulse && (evt.up == $past(nxt_bLvl == aLvl_ff)))
    else $error("x4 missed a B edge or its direction");
  a_static_dir: assert property ( // RL2
    !quad && aChg
    && ((edgeMode == depc_pkg::DEPC_EDGE_X2) || (edgeMode == depc_pkg::DEPC_EDGE_X4))
    |=> evt.pulse && (evt.up == !bLvl_ff))
    else $error("static direction not taken from B");
  c_x4_count: cover property (quad && (edgeMode == depc_pkg::DEPC_EDGE_X4) && bChg);

endmodule : depc_quad_decode
`default_nettype wire

// File: hdl/depc_counter.sv
// Dual encoder counting core: scaling, round loop, preset and restore
`timescale 1ns/1ns
`default_nettype none
// Function
// [RL1] Load command sets the chosen counter to its preset, clamped -199999..999999.
// [RL2] Input type 0/1 counts A/B quadrature; 2/3 counts A, B gives direction.
// [RL3] Edge setting 0/1/2 selects x1, x2 or x4 counting; with input type 2/3, setting 2 counts both A edges only, as x2.
// [RL4] Direction bit 0 counts up when A leads B; 1 counts down.
// [RL5] Each impulse is weighted by a scale of 0.00001..9.99999, default 1.
// [RL6] Each impulse counts multiplier times; limit 99 for channel 1, 999 for 2.
// [RL7] Nonzero loop limit wraps the counter within 0..limit; zero is unlimited.
// [RL8] Reset restarts at zero, or restores the saved count when memory is on.
// [RL9] Load codes: 4 loads counter 1, 5 counter 2, 6 both.
// [RL10] Fractional residue is carried between edges so totals never drift.
module depc_counter (
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  input  wire logic [1:0]              enc1APin,
  input  wire logic [1:0]              enc1BPin_unused_dummy,
  input  wire logic                    enc2APin,
  input  wire logic                    enc2BPin,
  input  wire logic [1:0][1:0]         inputType,
  input  wire logic [1:0][1:0]         edgeMode,
  input  wire logic [1:0]              dirInvert,
  input  wire logic [1:0][19:0]        scaleFactor,
  input  wire logic [1:0][9:0]         multiplier,
  input  wire logic [1:0][19:0]        loopLimit,
  input  wire logic [1:0][31:0]        presetValue,
  input  wire logic                    loadStrobe,
  input  wire logic [3:0]              loadCode,
  input  wire logic                    powerMemEn,
  input  wire logic [1:0][31:0]        restoreCount,
  output logic      [1:0][31:0]        count_ff
);

  // ==========================================================================
  // Helpers
  function automatic int depc_clamp(input int v, input int lo, input int hi);
    depc_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : depc_clamp

  function automatic int depc_wrap(input int v, input int lim);
    int m;
    int r;
    // Negative remainders fold up, so a reverse step below zero lands at the top
    m = lim + 1;
    r = v % m;
    if (r < 0) begin
      r = r + m;
    end
    depc_wrap = (lim == 0) ? v : r;
  endfunction : depc_wrap

  // Code 6 addresses both channels at once
  function automatic logic depc_load_hit(input logic [3:0] code, input int ch);
    logic one;
    one = (ch == 0) ? (code == depc_pkg::DEPC_CMD_LOAD1)
                    : (code == depc_pkg::DEPC_CMD_LOAD2);
    depc_load_hit = one || (code == depc_pkg::DEPC_CMD_LOADBOTH);
  endfunction : depc_load_hit

  // ==========================================================================
  // Channel decoders
  depc_evt_if evt1 ();
  depc_evt_if evt2 ();

  depc_quad_decode u_dec1 (
    .clk       (clk),
    .reset_n   (reset_n),
    .aPin      (enc1APin[0]),
    .bPin      (enc1APin[1]),
    .inputType (inputType[0]),
    .edgeMode  (edgeMode[0]),
    .evt       (evt1.src)
  );

  depc_quad_decode u_dec2 (
    .clk       (clk),
    .reset_n   (reset_n),
    .aPin      (enc2APin),
    .bPin      (enc2BPin),
    .inputType (inputType[1]),
    .edgeMode  (edgeMode[1]),
    .evt       (evt2.src)
  );

  // ==========================================================================
  // Counting
  logic [1:0]        evtPulse;
  logic [1:0]        evtUp;
  logic [1:0]        load;
  int                multC   [2];
  int                scaleC  [2];
  int                limC    [2];
  int                presetC [2];
  int                whole   [2];
  int                nres    [2];
  int                res_ff  [2];
  int                nxt_res [2];
  logic [1:0][31:0]  nxt_count;

  assign evtPulse = {evt2.pulse, evt1.pulse};
  assign evtUp    = {evt2.up, evt1.up};

  always_comb begin
    int sum;
    int step;
    sum  = 0;
    step = 0;
    // Unknown codes fall through and leave both counts alone
    load[0] = loadStrobe && depc_load_hit(loadCode, 0); // RL9
    load[1] = loadStrobe && depc_load_hit(loadCode, 1); // RL9
    for (int ch = 0; ch < 2; ch++) begin
      multC[ch]   = depc_clamp(int'(multiplier[ch]), depc_pkg::DEPC_MULT_MIN,
                               (ch == 0) ? depc_pkg::DEPC_MULT_MAX1
                                         : depc_pkg::DEPC_MULT_MAX2); // RL6
      scaleC[ch]  = depc_clamp(int'(scaleFactor[ch]), depc_pkg::DEPC_SCALE_MIN,
                               depc_pkg::DEPC_SCALE_MAX); // RL5
      limC[ch]    = depc_clamp(int'(loopLimit[ch]), 0, depc_pkg::DEPC_LOOP_MAX);
      presetC[ch] = depc_clamp(int'(signed'(presetValue[ch])), depc_pkg::DEPC_PRESET_MIN,
                               depc_pkg::DEPC_PRESET_MAX); // RL1
      // Up to 999 x 999999 per edge, still inside 32 bits
      step = multC[ch] * scaleC[ch]; // RL6 RL5
      sum  = res_ff[ch] + (((evtUp[ch] ^ dirInvert[ch]) == 1'b1) ? step : -step); // RL4
      whole[ch] = sum / depc_pkg::DEPC_SCALE_ONE; // RL10
      nres[ch]  = sum - whole[ch] * depc_pkg::DEPC_SCALE_ONE; // RL10
      nxt_count[ch] = count_ff[ch];
      nxt_res[ch]   = res_ff[ch];
      // Load beats a same-cycle edge; residue restarts clean
      if (load[ch]) begin
        nxt_count[ch] = presetC[ch]; // RL1
        nxt_res[ch]   = 0;
      end else if (evtPulse[ch]) begin
        nxt_count[ch] = depc_wrap(int'(signed'(count_ff[ch])) + whole[ch], limC[ch]); // RL7
        nxt_res[ch]   = nres[ch]; // RL10
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int ch = 0; ch < 2; ch++) begin
        // Synchronous reset, so sampling the restore port is legal here
        count_ff[ch] <= powerMemEn ? restoreCount[ch] : depc_pkg::DEPC_COUNT_RST; // RL8
        res_ff[ch]   <= 0;
      end
    end else begin
      count_ff <= nxt_count;
      res_ff   <= nxt_res;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Loads; the other counter may only move on its own edge
  a_load_one: assert property ( // RL1
    loadStrobe && (loadCode == depc_pkg::DEPC_CMD_LOAD1)
    |=> (signed'(count_ff[0]) == $past(presetC[0]))
        && ($stable(count_ff[1]) || $past(evtPulse[1])))
    else $error("counter 1 load wrong");
  a_load_two: assert property ( // RL9
    loadStrobe && (loadCode == depc_pkg::DEPC_CMD_LOAD2)
    |=> (signed'(count_ff[1]) == $past(presetC[1]))
        && ($stable(count_ff[0]) || $past(evtPulse[0])))
    else $error("counter 2 load wrong");
  a_preset_clamp: assert property ( // RL1
    load[0] |=> (signed'(count_ff[0]) >= depc_pkg::DEPC_PRESET_MIN)
            && (signed'(count_ff[0]) <= depc_pkg::DEPC_PRESET_MAX))
    else $error("counter 1 preset outside range");
  a_load_residue: assert property ( // RL10
    load[1] |=> (res_ff[1] == 0))
    else $error("counter 2 residue kept over a load");
  a_load_both: assert property ( // RL9
    loadStrobe && (loadCode == depc_pkg::DEPC_CMD_LOADBOTH)
    |=> (signed'(count_ff[0]) == $past(presetC[0])) && (signed'(count_ff[1]) == $past(presetC[1])))
    else $error("dual load wrong");

  // Counting steps and round loop
  a_count_step: assert property ( // RL4
    evtPulse[0] && !load[0] && (limC[0] == 0)
    |=> signed'(count_ff[0]) == $past(signed'(count_ff[0])) + $past(whole[0]))
    else $error("counter 1 step wrong");
  a_unit_dir: assert property ( // RL4
    evtPulse[1] && !load[1] && (limC[1] == 0) && (multC[1] == 1) && (scaleC[1] == 100000)
    && (res_ff[1] == 0)
    |=> signed'(count_ff[1]) == $past(signed'(count_ff[1])) + ($past(evtUp[1] ^ dirInvert[1]) ? 1 : -1))
    else $error("unit count sign wrong");
  a_loop_range: assert property ( // RL7
    evtPulse[0] && !load[0] && (limC[0] != 0)
    |=> (signed'(count_ff[0]) >= 0) && (signed'(count_ff[0]) <= $past(limC[0])))
    else $error("round loop left its range");
  a_loop_two: assert property ( // RL7
    evtPulse[1] && !load[1] && (limC[1] != 0)
    |=> (signed'(count_ff[1]) >= 0) && (signed'(count_ff[1]) <= $past(limC[1])))
    else $error("round loop 2 left its range");

  // Residue stays under one unit, else long runs would drift
  a_residue_bound: assert property ( // RL10
    (res_ff[0] < depc_pkg::DEPC_SCALE_ONE) && (res_ff[0] > -depc_pkg::DEPC_SCALE_ONE))
    else $error("residue out of bounds");
  a_residue_two: assert property ( // RL10
    (res_ff[1] < depc_pkg::DEPC_SCALE_ONE) && (res_ff[1] > -depc_pkg::DEPC_SCALE_ONE))
    else $error("residue 2 out of bounds");
  a_mult_limit: assert property ( // RL6
    (multC[0] <= depc_pkg::DEPC_MULT_MAX1) && (multC[1] <= depc_pkg::DEPC_MULT_MAX2)
    && (multC[0] >= 1) && (scaleC[0] >= 1))
    else $error("multiplier outside range");

  // A count moves only on an edge or a load
  a_hold_one: assert property (!load[0] && !evtPulse[0] |=> $stable(count_ff[0])) // RL9
    else $error("counter 1 moved without a cause");
  a_hold_two: assert property (!load[1] && !evtPulse[1] |=> $stable(count_ff[1])) // RL9
    else $error("counter 2 moved without a cause");

  // Reset checks run while reset is held, so nothing disables them
  a_reset_clear: assert property (@(posedge clk) disable iff (1'b0) // RL8
    !reset_n && !powerMemEn |=> count_ff == '0)
    else $error("count not cleared by reset");
  a_reset_restore: assert property (@(posedge clk) disable iff (1'b0) // RL8
    !reset_n && powerMemEn |=> count_ff == $past(restoreCount))
    else $error("count not restored");

  c_load_both: cover property (loadStrobe && (loadCode == depc_pkg::DEPC_CMD_LOADBOTH));
  c_wrap: cover property (evtPulse[0] && (limC[0] != 0) && (whole[0] != 0));
  c_fraction: cover property (evtPulse[1] && (nres[1] != 0) && (whole[1] == 0));
  c_restore: cover property (@(posedge clk) disable iff (1'b0) !reset_n && powerMemEn);

endmodule : depc_counter
`default_nettype wire

// File: verif/depc_enc_model.sv
// Encoder partner model: quadrature or count-plus-direction pin driver
`timescale 1ns/1ns
`default_nettype none
module depc_enc_model (
  input  wire logic clk,
  input  wire logic stepReq,
  input  wire logic stepFwd,
  input  wire logic staticMode,
  output logic      aPin,
  output logic      bPin
);
  logic [2:0] pend;
  initial begin
    aPin = 1'b0;
    bPin = 1'b0;
    pend = 3'h0;
  end
  // Direction level settles well before the counted A edge
  always @(posedge clk) begin
    if (pend != 3'h0) pend <= pend - 3'h1;
    if (pend == 3'h1) aPin <= ~aPin;
    if (stepReq && staticMode) begin
      bPin <= ~stepFwd;
      pend <= 3'h4;
    end else if (stepReq) begin
      aPin <= stepFwd ? ~bPin : bPin;
      bPin <= stepFwd ? aPin : ~aPin;
    end
  end
endmodule : depc_enc_model
`default_nettype wire

// File: verif/dual_encoder_position_counter_tb.sv
// Self-checking bench for the dual encoder counting core
`timescale 1ns/1ns
`default_nettype none
module dual_encoder_position_counter_tb;
  logic             clk, reset_n, loadStrobe, powerMemEn;
  logic [3:0]       loadCode;
  logic [1:0]       dirInvert, stepReq, stepFwd, pa, pb;
  logic [1:0][1:0]  inputType, edgeMode;
  logic [1:0][19:0] scaleFactor, loopLimit;
  logic [1:0][9:0]  multiplier;
  logic [1:0][31:0] presetValue, restoreCount, count;
  wire logic [1:0]  aP, bP;
  longint           expC[2], res[2];
  int               errors, total_checks;
  depc_enc_model enc0_u (.clk(clk), .stepReq(stepReq[0]), .stepFwd(stepFwd[0]),
    .staticMode(inputType[0][1]), .aPin(aP[0]), .bPin(bP[0]));
  depc_enc_model enc1_u (.clk(clk), .stepReq(stepReq[1]), .stepFwd(stepFwd[1]),
    .staticMode(inputType[1][1]), .aPin(aP[1]), .bPin(bP[1]));
  depc_counter dut_u (.clk(clk), .reset_n(reset_n), .enc1APin({bP[0], aP[0]}),
    .enc1BPin_unused_dummy(2'h0), .enc2APin(aP[1]), .enc2BPin(bP[1]),
    .inputType(inputType), .edgeMode(edgeMode), .dirInvert(dirInvert),
    .scaleFactor(scaleFactor), .multiplier(multiplier), .loopLimit(loopLimit),
    .presetValue(presetValue), .loadStrobe(loadStrobe), .loadCode(loadCode),
    .powerMemEn(powerMemEn), .restoreCount(restoreCount), .count_ff(count));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================================
  // Reference model
  function automatic void add(int i, longint s);
    longint inc;
    longint m;
    res[i] += s * longint'(multiplier[i]) * longint'(scaleFactor[i]);
    inc = res[i] / depc_pkg::DEPC_SCALE_ONE;
    res[i] -= inc * depc_pkg::DEPC_SCALE_ONE;
    expC[i] += inc;
    expC[i] = longint'(int'(expC[i]));
    m = longint'(loopLimit[i]) + 1;
    if (loopLimit[i] != 20'h0) begin
      expC[i] = expC[i] % m;
      if (expC[i] < 0) expC[i] += m;
    end
  endfunction : add
  function automatic void predict(int i, logic fwd);
    logic na, nb, cnt, up, x1;
    up = 1'b0;
    x1 = (edgeMode[i] == 2'h0) || (edgeMode[i] == 2'h3);
    if (inputType[i][1]) begin
      na = ~pa[i];
      nb = ~fwd;
      cnt = x1 ? na : 1'b1;
      up = ~nb;
    end else begin
      na = fwd ? ~pb[i] : pb[i];
      nb = fwd ? pa[i] : ~pa[i];
      cnt = x1 ? na : 1'b1;
      up = na ^ nb;
      if (na == pa[i]) begin
        cnt = (edgeMode[i] == 2'h2);
        up = ~(na ^ nb);
      end
    end
    pa[i] = na;
    pb[i] = nb;
    if (cnt) add(i, (up ^ dirInvert[i]) ? 1 : -1);
  endfunction : predict
  function automatic longint exp_preset(logic [31:0] p);
    longint v;
    v = longint'($signed(p));
    if (v < depc_pkg::DEPC_PRESET_MIN) v = depc_pkg::DEPC_PRESET_MIN;
    if (v > depc_pkg::DEPC_PRESET_MAX) v = depc_pkg::DEPC_PRESET_MAX;
    exp_preset = v;
  endfunction : exp_preset
  // ==========================================================================
  // Drivers and comparisons
  task automatic check_count(int i);
    total_checks++;
    if (count[i] !== expC[i][31:0]) begin
      errors++;
      $display("mismatch t=%0t ch%0d got %0d exp %0d", $time, i, $signed(count[i]), expC[i]);
    end
  endtask : check_count
  task automatic step_all();
    @(negedge clk);
    stepReq = 2'h3;
    stepFwd = 2'($urandom);
    @(negedge clk);
    stepReq = 2'h0;
    for (int i = 0; i < 2; i++) predict(i, stepFwd[i]);
    repeat (12) @(negedge clk);
    check_count(0);
    check_count(1);
  endtask : step_all
  task automatic do_reset(logic mem);
    @(negedge clk);
    reset_n = 1'b0;
    powerMemEn = mem;
    restoreCount = {32'($urandom), 32'($urandom)};
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    for (int i = 0; i < 2; i++) begin
      expC[i] = mem ? longint'($signed(restoreCount[i])) : 0;
      res[i] = 0;
    end
    check_count(0);
    check_count(1);
  endtask : do_reset
  task automatic do_load(logic [3:0] code);
    @(negedge clk);
    loadStrobe = 1'b1;
    loadCode = code;
    @(negedge clk);
    loadStrobe = 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (code == 4'h6 || code == 4'(4 + i)) begin
        expC[i] = exp_preset(presetValue[i]);
        res[i] = 0;
      end
    end
    repeat (2) @(negedge clk);
    check_count(0);
    check_count(1);
  endtask : do_load
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #200000;
    errors++;
    report_and_stop();
  end
  // ==========================================================================
  // Tests
  initial begin
    {reset_n, loadStrobe, powerMemEn, loadCode, stepReq, stepFwd, pa, pb} = '0;
    inputType = {2{depc_pkg::DEPC_INTYPE_RST}};
    edgeMode = {2{depc_pkg::DEPC_EDGE_RST}};
    dirInvert = {2{depc_pkg::DEPC_DIR_RST}};
    scaleFactor = {2{depc_pkg::DEPC_SCALE_RST}};
    multiplier = {2{depc_pkg::DEPC_MULT_RST}};
    {loopLimit, presetValue, restoreCount, errors, total_checks} = '0;
    void'($urandom(78));
    do_reset(1'b0);
    step_all();
    do_reset(1'b1);
    $display("test reset done");
    for (int it = 0; it < 4; it++) begin
      for (int em = 0; em < 3; em++) begin
        inputType = {2'(3 - it), 2'(it)};
        edgeMode = {2'(2 - em), 2'(em)};
        dirInvert = 2'(it + em);
        repeat (4) step_all();
      end
    end
    $display("test modes done");
    inputType = 4'h5;
    for (int n = 0; n < 16; n++) begin
      edgeMode = 4'($urandom_range(10, 0));
      scaleFactor[0] = (n == 0) ? 20'h1 : 20'($urandom_range(999999, 1));
      scaleFactor[1] = (n == 0) ? 20'hf423f : 20'($urandom_range(999999, 1));
      multiplier[0] = (n == 1) ? 10'h63 : 10'($urandom_range(99, 1));
      multiplier[1] = (n == 1) ? 10'h3e7 : 10'($urandom_range(999, 1));
      repeat (5) step_all();
    end
    $display("test scaling done");
    scaleFactor = {2{20'h186a0}};
    for (int n = 0; n < 6; n++) begin
      multiplier = {10'($urandom_range(9, 1)), 10'($urandom_range(9, 1))};
      loopLimit = {(n == 0) ? 20'hf423f : 20'($urandom_range(20, 1)), 20'($urandom_range(20, 1))};
      repeat (10) step_all();
    end
    loopLimit = '0;
    $display("test loop done");
    scaleFactor = {20'h30d41, 20'h1d4c1};
    presetValue = {32'hf423f, 32'hfffcf2c1};
    for (int c = 3; c < 8; c++) begin
      step_all();
      do_load(4'(c));
      presetValue = {32'(int'($urandom_range(1199998, 0)) - 199999), 32'($urandom)};
      presetValue[0] = c[0] ? 32'($urandom) : 32'(int'($urandom_range(1199998, 0)) - 199999);
    end
    step_all();
    do_reset(1'b1);
    $display("test load done");
    report_and_stop();
  end
endmodule : dual_encoder_position_counter_tb
`default_nettype wire
